// ==== hw/pc_card_window_enables.sv ====
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pc_card_window_enables (
    // Clock and reset
    input  wire logic                                     ref_clk,
    input  wire logic                                     reset_n,
    // Register port
    input  wire logic [card_win_pkg::REG_ADDR_W-1:0]      reg_addr,
    input  wire logic [card_win_pkg::REG_DATA_W-1:0]      reg_wdata,
    input  wire logic                                     reg_wr,
    input  wire logic                                     reg_rd,
    output logic      [card_win_pkg::REG_DATA_W-1:0]      reg_rdata,
    // Window bounds and memory offsets from the boundary registers
    input  wire logic [card_win_pkg::NUM_MEM_WIN-1:0][card_win_pkg::SYS_ADDR_W-1:0]  mem_start,
    input  wire logic [card_win_pkg::NUM_MEM_WIN-1:0][card_win_pkg::SYS_ADDR_W-1:0]  mem_stop,
    input  wire logic [card_win_pkg::NUM_MEM_WIN-1:0][card_win_pkg::CARD_ADDR_W-1:0] mem_offset,
    input  wire logic [card_win_pkg::NUM_IO_WIN-1:0][card_win_pkg::IO_ADDR_W-1:0]    io_start,
    input  wire logic [card_win_pkg::NUM_IO_WIN-1:0][card_win_pkg::IO_ADDR_W-1:0]    io_stop,
    // System bus cycle
    input  wire logic                                     cyc_valid,
    input  wire logic                                     cyc_is_io,
    input  wire logic [card_win_pkg::SYS_ADDR_W-1:0]      cyc_addr,
    // Card side
    output logic                                          card_enable,
    output logic      [card_win_pkg::CARD_ADDR_W-1:0]     card_addr
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [card_win_pkg::REG_DATA_W-1:0]     enable;    // Window enable register
        logic [card_win_pkg::REG_DATA_W-1:0]     hit;       // Last hit status
        logic                                    card_en;   // Card enable strobe
        logic [card_win_pkg::CARD_ADDR_W-1:0]    card_addr; // Card address
        logic [card_win_pkg::REG_DATA_W-1:0]     rdata;     // Read data
    } state_t;

    state_t state_ff;   // Registered state
    state_t nxt_state;  // Next state

    logic [card_win_pkg::NUM_MEM_WIN-1:0] mem_in;   // Address inside memory window
    logic [card_win_pkg::NUM_IO_WIN-1:0]  io_in;    // Address inside I/O window
    logic [card_win_pkg::NUM_MEM_WIN-1:0] mem_hit;  // Enabled memory hit
    logic [card_win_pkg::NUM_IO_WIN-1:0]  io_hit;   // Enabled I/O hit
    logic [card_win_pkg::NUM_MEM_WIN-1:0] mem_en;   // memory_window_enable_bits
    logic [card_win_pkg::NUM_IO_WIN-1:0]  io_en;    // io_window_enable_bits
    logic [card_win_pkg::IO_ADDR_W-1:0]   io_addr;  // Low part of system address

    // Enable fields sliced out of the control register
    assign mem_en  = state_ff.enable[card_win_pkg::MEM_EN_LSB +: card_win_pkg::NUM_MEM_WIN];
    assign io_en   = state_ff.enable[card_win_pkg::IO_EN_LSB +: card_win_pkg::NUM_IO_WIN];
    // I/O windows see only the low address bits; the upper ones are ignored
    assign io_addr = cyc_addr[card_win_pkg::IO_ADDR_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Range compare per memory window, each evaluated on its own
    genvar gm;
    generate
        for (gm = 0; gm < card_win_pkg::NUM_MEM_WIN; gm++) begin : g_mem
            assign mem_in[gm]  = (cyc_addr >= mem_start[gm]) &&
                                 (cyc_addr <= mem_stop[gm]);
            assign mem_hit[gm] = cyc_valid && !cyc_is_io &&
                                 mem_in[gm] && mem_en[gm];
            // A lone hit in this window lands at address plus this window's offset
            AST_MEM_WIN_OFFSET: assert property (
                @(posedge ref_clk) disable iff (!reset_n)
                ($onehot(mem_hit) && mem_hit[gm]) |=>
                (card_addr == card_win_pkg::CARD_ADDR_W'($past(cyc_addr))
                              + $past(mem_offset[gm])))
                else $error("Memory card address not offset by its window");
        end
    endgenerate

    // Range compare per I/O window
    genvar gi;
    generate
        for (gi = 0; gi < card_win_pkg::NUM_IO_WIN; gi++) begin : g_io
            assign io_in[gi]  = (io_addr >= io_start[gi]) &&
                                (io_addr <= io_stop[gi]);
            assign io_hit[gi] = cyc_valid && cyc_is_io &&
                                io_in[gi] && io_en[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next state: register port, window decode, card address
    always_comb begin
        nxt_state         = state_ff;
        nxt_state.rdata   = '0;
        nxt_state.card_en = 1'b0;
        // Strobes never overlap, so a write and a read share no cycle
        // Register write, reserved bit dropped; other offsets fall away
        if (reg_wr && (reg_addr == card_win_pkg::WIN_ENABLE_OFS)) begin
            nxt_state.enable = reg_wdata & card_win_pkg::WIN_ENABLE_MASK;
        end
        // Register read, unmapped reads zero
        if (reg_rd) begin
            case (reg_addr)
                card_win_pkg::WIN_ENABLE_OFS: nxt_state.rdata = state_ff.enable;
                card_win_pkg::HIT_STATUS_OFS: nxt_state.rdata = state_ff.hit;
                default:                      nxt_state.rdata = '0;
            endcase
        end
        // A cycle is either I/O or memory, so this order only shapes the branches
        // I/O cycle inside an enabled window
        if (|io_hit) begin
            nxt_state.card_en   = 1'b1;
            nxt_state.card_addr = {{(card_win_pkg::CARD_ADDR_W
                                   - card_win_pkg::IO_ADDR_W){1'b0}}, io_addr};
        end else if (|mem_hit) begin
            // Memory cycle: lowest numbered window wins
            nxt_state.card_en = 1'b1;
            // Walk from the top down so the lowest hit window is written last
            for (int i = card_win_pkg::NUM_MEM_WIN - 1; i >= 0; i--) begin
                if (mem_hit[i]) begin
                    // Sum wraps at card width: the offset is modulo the card space
                    nxt_state.card_addr = card_win_pkg::CARD_ADDR_W'(cyc_addr)
                                        + mem_offset[i];
                end
            end
        end
        // Status of the last decoded cycle
        if (cyc_valid) begin
            nxt_state.hit = {(|io_hit) || (|mem_hit), io_hit, mem_hit};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register, synchronous reset
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            // Every output, the enable register and the hit status clear
            state_ff           <= '0;
            state_ff.enable    <= card_win_pkg::WIN_ENABLE_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs come straight from the state flip-flops
    assign reg_rdata   = state_ff.rdata;
    assign card_enable = state_ff.card_en;
    assign card_addr   = state_ff.card_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Checks: each looks one edge ahead, as every output is registered

    // An I/O cycle inside an enabled window strobes the card next cycle
    AST_IO_HIT_ENABLES: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cyc_valid && cyc_is_io && |(io_in & io_en)) |=> card_enable)
        else $error("I/O window hit did not raise card enable");

    // An I/O cycle outside every enabled window leaves the card alone
    AST_IO_DISABLED_QUIET: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cyc_valid && cyc_is_io && ((io_in & io_en) == '0)) |=> !card_enable)
        else $error("Card enable raised for a disabled I/O window");

    // I/O addresses reach the card untranslated, upper card bits zero
    AST_IO_ADDR_PASS: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cyc_valid && cyc_is_io && |(io_in & io_en)) |=>
        (card_addr == {{(card_win_pkg::CARD_ADDR_W - card_win_pkg::IO_ADDR_W){1'b0}},
                       $past(io_addr)}))
        else $error("I/O card address differs from system address");

    // A memory cycle in no enabled window is ignored
    AST_MEM_DISABLED_QUIET: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cyc_valid && !cyc_is_io && ((mem_in & mem_en) == '0)) |=> !card_enable)
        else $error("Card enable raised for a disabled memory window");

    // A memory cycle in enabled window 0 strobes the card
    AST_MEM_HIT_ENABLES: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cyc_valid && !cyc_is_io && mem_in[0] && mem_en[0]) |=> card_enable)
        else $error("Memory window hit did not raise card enable");

    // Window 0 has the top priority, so its offset always applies when it hits
    AST_MEM_OFFSET: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cyc_valid && !cyc_is_io && mem_in[0] && mem_en[0]) |=>
        (card_addr == card_win_pkg::CARD_ADDR_W'($past(cyc_addr))
                      + $past(mem_offset[0])))
        else $error("Memory card address not offset by window 0");

    // No bus cycle, no strobe: the enable never stretches
    AST_STROBE_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !cyc_valid |=> !card_enable)
        else $error("Card enable raised without a bus cycle");

    // A miss or a disabled window leaves the card address as it was
    AST_MISS_HOLDS_ADDR: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !((|io_hit) || (|mem_hit)) |=> $stable(card_addr))
        else $error("Card address moved without a window hit");

    // Only window 0 on: one past its stop is outside
    AST_RANGE_LIMIT: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cyc_valid && !cyc_is_io && (cyc_addr > mem_stop[0]) && mem_en[0] &&
         (mem_en[card_win_pkg::NUM_MEM_WIN-1:1] == '0)) |=> !card_enable)
        else $error("Card enabled above window stop");

    // Only window 0 on: one below its start is outside
    AST_RANGE_BELOW: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cyc_valid && !cyc_is_io && (cyc_addr < mem_start[0]) && mem_en[0] &&
         (mem_en[card_win_pkg::NUM_MEM_WIN-1:1] == '0)) |=> !card_enable)
        else $error("Card enabled below window start");

    // A write to the enable register lands next cycle, reserved bit dropped
    AST_ENABLE_WRITE_LANDS: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (reg_wr && (reg_addr == card_win_pkg::WIN_ENABLE_OFS)) |=>
        (state_ff.enable == ($past(reg_wdata) & card_win_pkg::WIN_ENABLE_MASK)))
        else $error("Enable register write did not land");

    // Read data stand for one cycle after a read strobe and are zero otherwise
    AST_RDATA_IDLE_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !reg_rd |=> (reg_rdata == '0))
        else $error("Read data not zero outside a read");

    // A read of the enable register returns the value held at the strobe
    AST_ENABLE_READBACK: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (reg_rd && (reg_addr == card_win_pkg::WIN_ENABLE_OFS)) |=>
        (reg_rdata == $past(state_ff.enable)))
        else $error("Enable register read returned a wrong value");

endmodule // pc_card_window_enables

`default_nettype wire

// ==== include/card_win_pkg.sv ====
`default_nettype none

package card_win_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_MEM_WIN  = 5;      // Memory windows
    localparam int NUM_IO_WIN   = 2;      // I/O windows
    localparam int SYS_ADDR_W   = 24;     // System bus address width
    localparam int IO_ADDR_W    = 16;     // I/O address width
    localparam int CARD_ADDR_W  = 26;     // Card address width
    localparam int REG_ADDR_W   = 8;      // Register port address width
    localparam int REG_DATA_W   = 8;      // Register port data width

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] WIN_ENABLE_OFS = 8'h06;  // card_window_enable_control
    localparam logic [7:0] HIT_STATUS_OFS = 8'h40;  // Last hit window status

    ////////////////////////////////////////////////////////////////////////////
    // Field layout of card_window_enable_control
    localparam int MEM_EN_LSB   = 0;      // memory_window_enable_bits [4:0]
    localparam int IO_EN_LSB    = 6;      // io_window_enable_bits [7:6]
    localparam logic [7:0] WIN_ENABLE_MASK  = 8'hdf;  // Bit 5 reserved, reads zero
    localparam logic [7:0] WIN_ENABLE_RESET = 8'h00;  // All windows off

    ////////////////////////////////////////////////////////////////////////////
    // Field layout of hit status: [4:0] memory hits, [6:5] I/O hits, [7] any
    localparam int HIT_IO_LSB   = 5;
    localparam int HIT_ANY_BIT  = 7;

endpackage : card_win_pkg

`default_nettype wire

// ==== test/card_socket_model.sv ====
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Card socket: counts enable strobes and keeps the last strobed address
module card_socket_model (
    // Clock and reset
    input  wire logic                                 ref_clk,
    input  wire logic                                 reset_n,
    // Card side
    input  wire logic                                 card_enable,
    input  wire logic [card_win_pkg::CARD_ADDR_W-1:0] card_addr,
    // Observation
    output logic      [7:0]                           strobe_count,
    output logic      [card_win_pkg::CARD_ADDR_W-1:0] strobed_addr
);
    // Reset clears the count; latch the address on each strobe
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            strobe_count <= 8'h00;
        end else if (card_enable === 1'b1) begin
            strobe_count <= strobe_count + 8'h01;
            strobed_addr <= card_addr;
        end
    end
endmodule // card_socket_model

`default_nettype wire

// ==== test/pc_card_window_enables_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Bench: register tasks, bus cycles and expected card behaviour
module pc_card_window_enables_tb_top;
    logic             ref_clk, reset_n, reg_wr, reg_rd, cyc_valid, cyc_is_io, card_enable;
    logic [7:0]       reg_addr, reg_wdata, reg_rdata, strobe_count;
    logic [4:0][23:0] mem_start, mem_stop;  // Memory window bounds
    logic [4:0][25:0] mem_offset;           // Memory window offsets
    logic [1:0][15:0] io_start, io_stop;    // I/O window bounds
    logic [23:0]      cyc_addr;
    logic [25:0]      card_addr, strobed_addr, exp_addr;
    int               fails, comparisons, n_strobes;

    pc_card_window_enables pc_card_window_enables_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mem_start(mem_start), .mem_stop(mem_stop),
        .mem_offset(mem_offset), .io_start(io_start), .io_stop(io_stop),
        .cyc_valid(cyc_valid), .cyc_is_io(cyc_is_io), .cyc_addr(cyc_addr),
        .card_enable(card_enable), .card_addr(card_addr));
    card_socket_model card_socket_model_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .card_enable(card_enable), .card_addr(card_addr), .strobe_count(strobe_count),
        .strobed_addr(strobed_addr));

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", {24'h0, exp}, {24'h0, reg_rdata});
    endtask
    // One system cycle; on a miss the card address must hold
    task automatic bus_cycle(input logic io, input logic [23:0] a, input logic hit,
                             input logic [25:0] tr);
        @(posedge ref_clk);
        cyc_valid <= 1'b1;
        cyc_is_io <= io;
        cyc_addr <= a;
        @(posedge ref_clk);
        cyc_valid <= 1'b0;
        if (hit) begin
            exp_addr = tr;
            n_strobes++;
        end
        #1 chk("card_enable", {31'h0, hit}, {31'h0, card_enable});
        chk("card_addr", {6'h0, exp_addr}, {6'h0, card_addr});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        tally_and_finish;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {reset_n, reg_wr, reg_rd, cyc_valid, cyc_is_io} = 5'h00;
        {reg_addr, reg_wdata, cyc_addr, exp_addr} = '0;
        {fails, comparisons, n_strobes} = '0;
        for (int w = 0; w < 5; w++) begin
            mem_start[w] = 24'h100000 + 24'(w) * 24'h010000;
            mem_stop[w] = mem_start[w] + 24'h000fff;
            mem_offset[w] = 26'h2000000 + 26'(w) * 26'h0001111;
        end
        for (int i = 0; i < 2; i++) begin
            io_start[i] = 16'h0300 + 16'(i) * 16'h0200;
            io_stop[i] = io_start[i] + 16'h00ff;
        end
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        reg_read(8'h06, 8'h00);
        reg_read(card_win_pkg::HIT_STATUS_OFS, 8'h00);
        // Bounds and offsets are already set before any enable goes high
        reg_write(8'h06, 8'hff);
        reg_read(8'h06, card_win_pkg::WIN_ENABLE_MASK);
        reg_read(8'h07, 8'h00);
        for (int w = 0; w < 5; w++) begin
            bus_cycle(1'b0, mem_start[w], 1'b1, 26'(mem_start[w]) + mem_offset[w]);
            bus_cycle(1'b0, mem_stop[w], 1'b1, 26'(mem_stop[w]) + mem_offset[w]);
            reg_read(card_win_pkg::HIT_STATUS_OFS, 8'h80 | (8'h01 << w));
            bus_cycle(1'b0, mem_stop[w] + 24'h1, 1'b0, 26'h0);
            bus_cycle(1'b0, mem_start[w] - 24'h1, 1'b0, 26'h0);
        end
        for (int i = 0; i < 2; i++) begin
            bus_cycle(1'b1, {8'h00, io_stop[i]}, 1'b1, {10'h0, io_stop[i]});
            reg_read(card_win_pkg::HIT_STATUS_OFS,
                     8'h80 | (8'h01 << (card_win_pkg::HIT_IO_LSB + i)));
            bus_cycle(1'b1, {8'h00, io_stop[i] + 16'h1}, 1'b0, 26'h0);
        end
        // Clear one memory enable at a time: its hits are ignored
        for (int w = 0; w < 5; w++) begin
            reg_write(8'h06, 8'hdf ^ (8'h01 << w));
            bus_cycle(1'b0, mem_start[w], 1'b0, 26'h0);
        end
        // Only window 0 on: both neighbours of its range miss, its inside hits
        reg_write(8'h06, 8'h01);
        bus_cycle(1'b0, mem_start[0] - 24'h1, 1'b0, 26'h0);
        bus_cycle(1'b0, mem_stop[0] + 24'h1, 1'b0, 26'h0);
        bus_cycle(1'b0, mem_start[0] + 24'h10, 1'b1,
                  26'(mem_start[0] + 24'h10) + mem_offset[0]);
        reg_write(8'h06, 8'h1f);
        bus_cycle(1'b1, {8'h00, io_start[0]}, 1'b0, 26'h0);
        chk("strobe_count", n_strobes, {24'h0, strobe_count});
        chk("strobed_addr", {6'h0, exp_addr}, {6'h0, strobed_addr});
        // Mid-run reset: enables, status and card address clear
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        reg_read(8'h06, 8'h00);
        reg_read(card_win_pkg::HIT_STATUS_OFS, 8'h00);
        exp_addr = '0;
        bus_cycle(1'b0, mem_start[0], 1'b0, 26'h0);
        tally_and_finish;
    end
endmodule // pc_card_window_enables_tb_top

`default_nettype wire
